// ===== pmrc_checker.sv
// Port assertions of the power-mode and reset control.
module pmrc_checker
	import pmrc_pkg::*;
(
	// Clock, reset and observed ports.
	input  wire logic             CLK_SYS_I,
	input  wire logic             RST_I,
	input  wire logic             SLEEP_INSTRUCTION_I,
	input  wire pmrc_pkg::wake_t  WAKE_I,
	input  wire pmrc_pkg::gates_t GATES_O,
	input  wire logic             CORE_RESET_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);
	wire run    = GATES_O.core_run;
	wire halted = !run && !GATES_O.losc_run && !CORE_RESET_O;
	wire stby   = !run && GATES_O.losc_run && !CORE_RESET_O;
	sequence s_halt_evt;
		halted && WAKE_I.ext_int;
	endsequence
	sequence s_stay_off;
		!run [*8] ##1 !run [*7];
	endsequence
	AST_RST_HOLD: assert property ($past(RST_I) |-> CORE_RESET_O)
		else $error("Core not held after reset.");
	AST_CORE_HELD: assert property (CORE_RESET_O && $past(CORE_RESET_O)
		|-> !run) else $error("Core runs while held.");
	AST_HALT_OFF: assert property (halted |-> !GATES_O.hosc_run
		&& !GATES_O.timer0_run && !GATES_O.timer1_run
		&& GATES_O.periph_run == '0) else $error("Gate on in halt.");
	AST_LOSC_RUN: assert property (!GATES_O.losc_run |-> !run)
		else $error("Core runs without low clock.");
	AST_SLEEP: assert property (run && SLEEP_INSTRUCTION_I
		&& !CORE_RESET_O |-> ##[1:2] !run) else $error("Sleep ignored.");
	AST_HALT_WAKE: assert property (s_halt_evt |=> s_stay_off
		##[1:2] run) else $error("Halt wake timing wrong.");
	AST_HALT_TIMER: assert property (halted && WAKE_I == 6'h31
		|=> !run) else $error("Timer woke halt.");
	AST_STBY_WAKE: assert property (stby && WAKE_I.timer0_ovf
		|-> ##[1:3] run) else $error("Standby did not wake.");
endmodule // pmrc_checker

// ===== pmrc_core_model.sv
// Processor core model issuing sleep and watchdog-clear strobes.
module pmrc_core_model
	import pmrc_pkg::*;
(
	// Clock, gates and strobes.
	input  wire logic             clk_i,
	input  wire pmrc_pkg::gates_t gates_i,
	output logic                  sleep_o,
	output logic                  clear_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sleep_o = 1'b0;
		clear_o = 1'b0;
	end
	// One-cycle strobe, only while the core executes.
	task automatic issue(input logic is_sleep);
		@(posedge clk_i);
		sleep_o <= is_sleep && gates_i.core_run;
		clear_o <= !is_sleep && gates_i.core_run;
		@(posedge clk_i);
		sleep_o <= 1'b0;
		clear_o <= 1'b0;
	endtask
endmodule // pmrc_core_model

// ===== pmrc_pkg.sv
// Package with constants, types and register map of the power-mode control.
package pmrc_pkg;

	localparam int CLK_HZ = 20000000;

	// Avalon-MM word offsets (byte addresses).
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_ENABLE = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_CONFIG = 4'hC;

	// Control register fields.
	localparam int CTRL_SEL_BIT  = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;

	// Enable register fields.
	localparam int EN_T0_BIT  = 0;
	localparam int EN_T1_BIT  = 1;
	localparam int EN_WDT_BIT = 2;
	localparam int EN_PER_LSB = 3;
	localparam int PER_W      = 4;

	// Status register fields.
	localparam int ST_PD_BIT   = 0;
	localparam int ST_TO_BIT   = 1;
	localparam int ST_MODE_LSB = 2;
	localparam int ST_RDY_BIT  = 4;

	// Configuration register fields.
	localparam int CFG_PWRT_LSB = 0;
	localparam int CFG_WDTO_BIT = 3;
	localparam int CFG_SCLK_BIT = 4;

	// Reset values and read data of unmapped offsets.
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RST = 32'h0000_0011;
	localparam logic [31:0] BAD_DATA   = 32'hDEAD_0000;

	// Operating-mode field encodings.
	localparam logic [1:0] OPERATING_MODE_FIELD_RUN     = 2'h0;
	localparam logic [1:0] OPERATING_MODE_FIELD_HALT    = 2'h1;
	localparam logic [1:0] OPERATING_MODE_FIELD_STANDBY = 2'h2;

	// Times, in their own units, and derived cycle counts.
	localparam int OST_CYCLES  = 16;
	localparam int WAKE_CYCLES = 16;
	localparam longint PWRT_NS [0:4] = '{140000, 4500000, 18000000,
		72000000, 288000000};
	localparam int CNT_W = 24;

	function automatic logic [CNT_W-1:0] ns_to_cycles(input longint ns);
		longint c;
		c = (ns * CLK_HZ) / 64'd1000000000;
		if (c < 1)
			c = 1;
		return c[CNT_W-1:0];
	endfunction

	typedef enum logic [2:0] {
		ST_RESET  = 3'h0,
		ST_PWRT   = 3'h1,
		ST_OST    = 3'h2,
		ST_NORMAL = 3'h3,
		ST_SLOW   = 3'h4,
		ST_STBY   = 3'h5,
		ST_HALT   = 3'h6,
		ST_WAKE   = 3'h7
	} pm_state_t;

	// Gates driven into the rest of the device.
	typedef struct packed {
		logic             hosc_run;
		logic             losc_run;
		logic             core_run;
		logic             timer0_run;
		logic             timer1_run;
		logic             wdt_run;
		logic [PER_W-1:0] periph_run;
	} gates_t;

	// Wake-up events from the peripherals.
	typedef struct packed {
		logic timer0_ovf;
		logic timer1_udf;
		logic wdt_timeout;
		logic portb_change;
		logic ext_int;
		logic low_voltage_detect;
	} wake_t;

endpackage : pmrc_pkg

// ===== power_mode_reset_control.sv
// Power-mode sequencing, reset sequencing and status flags of the core.
//
// Functional notes
// - HOSC on normal, stop-bit slow/standby, off halt.
// - LOSC runs except in halt mode.
// - Core executes only in normal and slow.
// - Timers follow enables; forced off in halt.
// - Watchdog follows option and enable always.
// - Peripherals follow enables; all off in halt.
// - Standby wakes on timers, watchdog, pins, voltage.
// - Halt wakes on watchdog, port change, interrupt.
// - Four reset events start reset sequence.
// - Reset loads defined register initial values; por, low-voltage, pin and watchdog resets keep config_ff.
// - Power, low-voltage, clear set flags; sleep clears pd.
// - Pin reset outside halt keeps flags.
// - Pin reset in halt sets both flags.
// - Watchdog reset outside halt: to 0, pd 1.
// - Watchdog reset in halt clears both flags.
// - Wait selected power-up time after release.
// - Then wait sixteen cycles of start-up.
// - Sleep or field 01 halts; 10 standby.
// - Wake resumes normal if select set, else slow.
// - Halt wake waits sixteen cycles; standby none.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
module power_mode_reset_control
	import pmrc_pkg::*;
(
	// Clock and reset.
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_I,
	// Avalon-MM slave.
	input  wire logic [3:0]        AVS_ADDRESS_I,
	input  wire logic              AVS_READ_I,
	input  wire logic              AVS_WRITE_I,
	input  wire logic [31:0]       AVS_WRITEDATA_I,
	input  wire logic [3:0]        AVS_BYTEENABLE_I,
	output logic      [31:0]       AVS_READDATA_O,
	output logic                   AVS_WAITREQUEST_O,
	output logic      [1:0]        AVS_RESPONSE_O,
	// Reset sources, from pins and analogue blocks.
	input  wire logic              POWER_ON_RESET_I,
	input  wire logic              LOW_VOLTAGE_RESET_I,
	input  wire logic              EXTERNAL_RESET_PIN_N_I,
	// Core instruction strobes, same clock domain.
	input  wire logic              SLEEP_INSTRUCTION_I,
	input  wire logic              WATCHDOG_CLEAR_INSTRUCTION_I,
	// Wake-up events.
	input  wire pmrc_pkg::wake_t   WAKE_I,
	// Gates and core control.
	output pmrc_pkg::gates_t       GATES_O,
	output logic                   CORE_RESET_O,
	output logic                   SYS_CLK_SEL_HOSC_O
);
	import pmrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State decodes and bus codes used in several places.

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [2:0] PWRT_MAX    = 3'h4;

	function automatic logic is_boot(input pm_state_t s);
		return (s == ST_RESET) || (s == ST_PWRT) || (s == ST_OST);
	endfunction

	function automatic logic is_run(input pm_state_t s);
		return (s == ST_NORMAL) || (s == ST_SLOW);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for asynchronous reset sources.

	logic [2:0] src_meta_ff;
	logic [2:0] src_sync_ff;
	logic       wdt_evt_ff;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			src_meta_ff <= 3'h0;
			src_sync_ff <= 3'h0;
		end else begin
			src_meta_ff <= {POWER_ON_RESET_I, LOW_VOLTAGE_RESET_I,
				~EXTERNAL_RESET_PIN_N_I};
			src_sync_ff <= src_meta_ff;
		end
	end

	wire por_w = src_sync_ff[2];
	wire lvr_w = src_sync_ff[1];
	wire pin_w = src_sync_ff[0];
	wire wdt_w = WAKE_I.wdt_timeout;
	wire any_rst_w = por_w | lvr_w | pin_w | wdt_w;

	////////////////////////////////////////////////////////////////////////
	// Registers.

	logic [31:0] ctrl_ff;
	logic [31:0] enable_ff;
	logic [31:0] config_ff;
	logic        to_ff;
	logic        pd_ff;
	pm_state_t   state_ff;
	pm_state_t   nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	wire in_halt_w  = (state_ff == ST_HALT);
	wire sel_w      = ctrl_ff[CTRL_SEL_BIT];
	wire stop_w     = ctrl_ff[CTRL_STOP_BIT];
	wire [1:0] operating_mode_field_w = ctrl_ff[CTRL_MODE_LSB +: 2];
	wire [2:0] pwrt_w = config_ff[CFG_PWRT_LSB +: 3];
	wire running_w  = is_run(state_ff);
	wire [2:0] pwrt_idx_w = (pwrt_w > PWRT_MAX) ? PWRT_MAX : pwrt_w;
	wire [CNT_W-1:0] pwrt_cyc_w = ns_to_cycles(PWRT_NS[pwrt_idx_w]);

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	wire acc_w     = AVS_READ_I | AVS_WRITE_I;
	wire hit_ctrl  = (AVS_ADDRESS_I == OFS_CTRL);
	wire hit_en    = (AVS_ADDRESS_I == OFS_ENABLE);
	wire hit_st    = (AVS_ADDRESS_I == OFS_STATUS);
	wire hit_cfg   = (AVS_ADDRESS_I == OFS_CONFIG);
	wire mapped_w  = hit_ctrl | hit_en | hit_st | hit_cfg;
	logic ack_ff;
	wire take_w    = acc_w & ~ack_ff;
	wire wr_w      = AVS_WRITE_I & take_w;
	wire [31:0] bmask_w = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
		{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
	wire [31:0] ctrl_wr_w = (ctrl_ff & ~bmask_w) | (AVS_WRITEDATA_I & bmask_w);
	wire mode_wr_w = wr_w & hit_ctrl & AVS_BYTEENABLE_I[0] & running_w;
	wire [1:0] new_operating_mode_field_w = AVS_WRITEDATA_I[CTRL_MODE_LSB +: 2];
	wire go_halt_w = (running_w & SLEEP_INSTRUCTION_I) |
		(mode_wr_w & (new_operating_mode_field_w == OPERATING_MODE_FIELD_HALT));
	wire go_stby_w = mode_wr_w & (new_operating_mode_field_w == OPERATING_MODE_FIELD_STANDBY);

	wire [31:0] status_w = {27'h0, !is_boot(state_ff),
		(in_halt_w ? OPERATING_MODE_FIELD_HALT : (state_ff == ST_STBY) ? OPERATING_MODE_FIELD_STANDBY :
		OPERATING_MODE_FIELD_RUN), to_ff, pd_ff};
	wire [31:0] rdata_w = hit_ctrl ? ctrl_ff : hit_en ? enable_ff :
		hit_st ? status_w : hit_cfg ? config_ff : BAD_DATA;

	// One wait cycle: the access completes on the second edge.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			ack_ff            <= 1'b0;
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O    <= 32'h0;
			AVS_RESPONSE_O    <= RESP_OKAY;
		end else begin
			ack_ff            <= take_w;
			AVS_WAITREQUEST_O <= ~take_w;
			AVS_READDATA_O    <= take_w ? rdata_w : 32'h0;
			AVS_RESPONSE_O    <= (take_w & ~mapped_w) ? RESP_DECERR
				: RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; reset loads defined values.

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_ff   <= CTRL_RST;
			enable_ff <= ENABLE_RST;
			config_ff <= CONFIG_RST;
		end else if (any_rst_w) begin
			ctrl_ff   <= CTRL_RST;
			enable_ff <= ENABLE_RST;
		end else begin
			if (state_ff == ST_OST && cnt_ff == '0)
				ctrl_ff[CTRL_SEL_BIT] <= config_ff[CFG_SCLK_BIT];
			else if (wr_w & hit_ctrl)
				ctrl_ff <= {28'h0, ctrl_wr_w[3:0]};
			if (wr_w & hit_en)
				enable_ff <= (enable_ff & ~bmask_w) |
					(AVS_WRITEDATA_I & bmask_w);
			if (wr_w & hit_cfg)
				config_ff <= {27'h0, (config_ff[4:0] & ~bmask_w[4:0]) |
					(AVS_WRITEDATA_I[4:0] & bmask_w[4:0])};
			if (go_halt_w | go_stby_w)
				ctrl_ff[CTRL_MODE_LSB +: 2] <= OPERATING_MODE_FIELD_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timeout and power-down flags; hardware events win over instructions.

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end else if (por_w | lvr_w) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end else if (wdt_w && state_ff != ST_RESET) begin
			to_ff <= 1'b0;
			pd_ff <= ~in_halt_w;
		end else if (pin_w && in_halt_w) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end else if (pin_w) begin
			to_ff <= to_ff;
			pd_ff <= pd_ff;
		end else if (go_halt_w && SLEEP_INSTRUCTION_I) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b0;
		end else if (WATCHDOG_CLEAR_INSTRUCTION_I && running_w) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and reset sequencer.

	wire wake_stby_w = WAKE_I.timer0_ovf | WAKE_I.timer1_udf |
		WAKE_I.wdt_timeout | WAKE_I.portb_change | WAKE_I.ext_int |
		WAKE_I.low_voltage_detect;
	wire wake_halt_w = WAKE_I.wdt_timeout | WAKE_I.portb_change |
		WAKE_I.ext_int;
	wire pm_state_t run_st_w = sel_w ? ST_NORMAL : ST_SLOW;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = (cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1;
		unique case (state_ff)
			ST_RESET: begin
				nxt_cnt = pwrt_cyc_w - 1'b1;
				if (!any_rst_w)
					nxt_state = ST_PWRT;
			end
			ST_PWRT: if (cnt_ff == '0) begin
				nxt_state = ST_OST;
				nxt_cnt   = CNT_W'(OST_CYCLES - 1);
			end
			ST_OST: if (cnt_ff == '0)
				nxt_state = config_ff[CFG_SCLK_BIT] ? ST_NORMAL
					: ST_SLOW;
			ST_NORMAL, ST_SLOW: begin
				if (go_halt_w)
					nxt_state = ST_HALT;
				else if (go_stby_w)
					nxt_state = ST_STBY;
				else if (wr_w & hit_ctrl & AVS_BYTEENABLE_I[0])
					nxt_state = ctrl_wr_w[CTRL_SEL_BIT] ? ST_NORMAL
						: ST_SLOW;
			end
			ST_STBY: if (wake_stby_w)
				nxt_state = run_st_w;
			ST_HALT: if (wake_halt_w) begin
				nxt_state = ST_WAKE;
				nxt_cnt   = CNT_W'(WAKE_CYCLES - 1);
			end
			ST_WAKE: if (cnt_ff == '0)
				nxt_state = run_st_w;
		endcase
		if (any_rst_w)
			nxt_state = ST_RESET;
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			state_ff <= ST_RESET;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output gates, registered.

	wire halt_n_w = (nxt_state != ST_HALT);
	gates_t nxt_gates;
	assign nxt_gates.hosc_run = (nxt_state == ST_NORMAL) ||
		(halt_n_w && !stop_w);
	assign nxt_gates.losc_run = halt_n_w;
	assign nxt_gates.core_run = is_run(nxt_state);
	assign nxt_gates.timer0_run = halt_n_w & enable_ff[EN_T0_BIT];
	assign nxt_gates.timer1_run = halt_n_w & enable_ff[EN_T1_BIT];
	assign nxt_gates.wdt_run = config_ff[CFG_WDTO_BIT] &
		enable_ff[EN_WDT_BIT];
	assign nxt_gates.periph_run = halt_n_w ?
		enable_ff[EN_PER_LSB +: PER_W] : '0;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			GATES_O            <= '0;
			CORE_RESET_O       <= 1'b1;
			SYS_CLK_SEL_HOSC_O <= 1'b1;
		end else begin
			GATES_O            <= nxt_gates;
			CORE_RESET_O       <= is_boot(nxt_state);
			SYS_CLK_SEL_HOSC_O <= (nxt_state == ST_NORMAL);
		end
	end

endmodule // power_mode_reset_control

// ===== power_mode_reset_control_bench.sv
// Self-checking bench of the power-mode and reset control.
module power_mode_reset_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pmrc_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic        por = 1'b0, low_voltage_reset = 1'b0, pin_n = 1'b1;
	logic        wreq, core_rst, sel_hosc, sleep, clr;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [1:0]  resp, qr;
	wake_t       wake = '0;
	gates_t      gates;
	int          num_errors = 0, check_count = 0, cycles = 0;
	always #25 clk = ~clk;
	power_mode_reset_control dut_u (.CLK_SYS_I(clk), .RST_I(rst),
		.AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
		.AVS_RESPONSE_O(resp), .POWER_ON_RESET_I(por),
		.LOW_VOLTAGE_RESET_I(low_voltage_reset), .EXTERNAL_RESET_PIN_N_I(pin_n),
		.SLEEP_INSTRUCTION_I(sleep), .WATCHDOG_CLEAR_INSTRUCTION_I(clr),
		.WAKE_I(wake), .GATES_O(gates), .CORE_RESET_O(core_rst),
		.SYS_CLK_SEL_HOSC_O(sel_hosc));
	pmrc_core_model core_u (.clk_i(clk), .gates_i(gates), .sleep_o(sleep),
		.clear_o(clr));
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		qr = resp;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic gate(input logic [9:0] e);
		repeat (3) @(posedge clk);
		chk("gates", {22'h0, e}, {22'h0, gates});
	endtask
	task automatic flags(input logic [1:0] e);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("flags", {30'h0, e}, {30'h0, q[1:0]});
	endtask
	task automatic wake_up(input wake_t w, input int n);
		@(posedge clk);
		wake <= w;
		@(posedge clk);
		wake <= '0;
		repeat (n) @(posedge clk);
	endtask
	task automatic boot(input logic [3:0] s, input logic [1:0] f);
		int n;
		n = 0;
		@(posedge clk);
		por  <= s[3];
		low_voltage_reset  <= s[2];
		pin_n <= !s[1];
		wake.wdt_timeout <= s[0];
		@(posedge clk);
		wake <= '0;
		repeat (3) @(posedge clk);
		por  <= 1'b0;
		low_voltage_reset  <= 1'b0;
		pin_n <= 1'b1;
		while (core_rst !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		chk("boot", 32'h1, {31'h0, n >= 2813 && n <= 2834});
		gate(10'h380);
		chk("sel", 32'h1, {31'h0, sel_hosc});
		flags(f);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", CTRL_RST, q);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_modes();
		bus(1'b1, OFS_CONFIG, 32'h18);
		boot(4'h8, 2'b11);
		bus(1'b1, OFS_ENABLE, 32'h7F);
		gate(10'h3FF);
		bus(1'b0, 4'h2, 32'h0);
		chk("decode", BAD_DATA, q);
		chk("response", 32'h3, {30'h0, qr});
		bus(1'b1, OFS_CTRL, 32'h9);
		gate(10'h37F);
		wake_up(6'h20, 0);
		gate(10'h3FF);
		chk("normal", 32'h1, {31'h0, sel_hosc});
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h8);
		wake_up(6'h04, 0);
		gate(10'h3FF);
		chk("slow", 32'h0, {31'h0, sel_hosc});
		bus(1'b1, OFS_CTRL, 32'h2);
		gate(10'h1FF);
		bus(1'b1, OFS_CTRL, 32'h5);
		gate(10'h010);
		wake_up(6'h02, 20);
		gate(10'h3FF);
		$display("test modes done");
	endtask
	task automatic t_halt();
		core_u.issue(1'b0);
		flags(2'b11);
		core_u.issue(1'b1);
		gate(10'h010);
		flags(2'b10);
		wake_up(6'h31, 0);
		gate(10'h010);
		wake_up(6'h02, 20);
		gate(10'h3FF);
		$display("test halt done");
	endtask
	task automatic t_resets();
		boot(4'h2, 2'b10);
		core_u.issue(1'b1);
		boot(4'h2, 2'b11);
		boot(4'h1, 2'b01);
		core_u.issue(1'b0);
		flags(2'b11);
		core_u.issue(1'b1);
		boot(4'h1, 2'b00);
		boot(4'h4, 2'b11);
		$display("test resets done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_modes();
		t_halt();
		t_resets();
		end_sim();
	end
endmodule // power_mode_reset_control_bench
bind power_mode_reset_control pmrc_checker chk_u (.CLK_SYS_I(CLK_SYS_I),
	.RST_I(RST_I), .SLEEP_INSTRUCTION_I(SLEEP_INSTRUCTION_I),
	.WAKE_I(WAKE_I), .GATES_O(GATES_O), .CORE_RESET_O(CORE_RESET_O));
